// ---- src/sar_ctrl_pkg.sv ----
/*
 * Shared constants and types for the converter control block: result
 * width, buffer depth, conversion and power-up timing, mode states.
 * Assumes a single 40 MHz reference clock for all timing counts.
 */
`default_nettype none

package sar_ctrl_pkg;

    localparam int RESULT_BITS = 12;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_TIME_NS = 650;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_TIME_US = 100;
    localparam int POWERUP_CYCLES =
        (POWERUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAR_CLK_DIV = 2;
    localparam int COUNT_W = 12;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
    localparam logic [3:0] TOP_BIT_INDEX = 4'hB;
    localparam logic [3:0] WORD_BITS = 4'hC;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_DOWN = 2'b10,
        ST_POWER_UP = 2'b11
    } mode_state_t;

endpackage
`default_nettype wire

// ---- src/sample_fifo.sv ----
/*
 * Result buffer: synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on the same clock; full and empty are exact.
 */
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = sar_ctrl_pkg::RESULT_BITS,
    parameter int DEPTH = sar_ctrl_pkg::FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    import sar_ctrl_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W:0] wr_ptr;
        logic [PTR_W:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic full;
    logic empty;

    assign empty = (st.wr_ptr == st.rd_ptr);
    assign full = (st.wr_ptr[PTR_W-1:0] == st.rd_ptr[PTR_W-1:0])
        && (st.wr_ptr[PTR_W] != st.rd_ptr[PTR_W]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = st.mem[st.rd_ptr[PTR_W-1:0]];

    always_comb
    begin
        next_st = st;
        if (i_in_valid && !full)
        begin
            next_st.mem[st.wr_ptr[PTR_W-1:0]] = i_in_data;
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (i_out_ready && !empty)
        begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire

// ---- src/sar_stepper.sv ----
/*
 * Successive-approximation stepper: walks the trial code from MSB to
 * LSB on an internal converter-clock enable, one comparator decision
 * per step. Assumes a latched comparator output on the reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_stepper (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_comparator_high,
    output logic [sar_ctrl_pkg::RESULT_BITS-1:0] o_dac_code,
    output logic o_done,
    output logic [sar_ctrl_pkg::RESULT_BITS-1:0] o_result
);
    import sar_ctrl_pkg::*;

    localparam int DIV_W = $clog2(SAR_CLK_DIV + 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic busy;
        logic [3:0] idx;
        logic [RESULT_BITS-1:0] code;
        logic done;
        logic [RESULT_BITS-1:0] result;
    } step_state_t;

    step_state_t st;
    step_state_t next_st;
    logic step_en;

    // --------------------------------------------------------------
    // Internal converter clock, independent of the serial clock
    // --------------------------------------------------------------
    assign step_en = (st.div == DIV_W'(SAR_CLK_DIV - 1));

    always_comb
    begin
        logic [RESULT_BITS-1:0] trial;
        trial = st.code;
        next_st = st;
        next_st.done = 1'b0;
        next_st.div = step_en ? '0 : DIV_W'(st.div + 1'b1);
        if (!i_comparator_high)
        begin
            trial[st.idx] = 1'b0;
        end
        if (i_start)
        begin
            next_st.busy = 1'b1;
            next_st.code = SAR_FIRST_TRIAL;
            next_st.idx = TOP_BIT_INDEX;
            next_st.div = '0;
        end
        else if (st.busy && step_en)
        begin
            next_st.code = trial;
            if (st.idx == 4'h0)
            begin
                // Straight binary, zero at bottom of range
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.result = trial;
            end
            else
            begin
                // Each code step is one DAC unit of supply over 4096
                next_st.code[st.idx - 4'h1] = 1'b1;
                next_st.idx = st.idx - 4'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_dac_code = st.code;
    assign o_done = st.done;
    assign o_result = st.result;

endmodule
`default_nettype wire

// ---- src/sar_adc_conversion_control.sv ----
/*
 * Conversion control and serial readout for a 12-bit SAR converter:
 * start-pin edge detection, conversion timing, normal/power-down mode,
 * power-up timing, result buffering and the framed serial output.
 * Assumes the host pins are asynchronous to the 40 MHz reference clock
 * and the serial clock is slow enough to be oversampled.
 */
// Functional notes
// - Result is 12-bit straight binary
// - Code step is supply over 4096
// - Falling start edge samples, starts conversion
// - Start level at end selects mode
// - Start low at end powers down
// - Serial readout works while powered down
// - Rising start edge powers up, 100 us
// - Result leaves a 12-bit shift register
// - Result sent MSB first
// - Internal clock times SAR steps
// - One conversion per microsecond supported
// - Conversion ends 650 ns after start
// - Output driven only while frame selected
// - Data bits change on serial clock fall
// - Frame level at end enables busy indicator
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_conversion_start_n,
    input wire logic i_frame_select_n,
    input wire logic i_serial_clock,
    input wire logic i_comparator_high,
    output logic o_serial_result_out,
    output logic o_serial_result_oe_n,
    output logic o_track_mode,
    output logic o_analog_power_on,
    output logic [sar_ctrl_pkg::RESULT_BITS-1:0] o_dac_code
);
    import sar_ctrl_pkg::*;

    typedef struct packed {
        // Pin synchronisers, third stage only for edge detection
        logic start_s1;
        logic start_s2;
        logic start_s3;
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        // Mode control
        mode_state_t mode;
        logic [COUNT_W-1:0] count;
        logic track;
        logic analog_on;
        logic push;
        logic [RESULT_BITS-1:0] push_word;
        // Serial readout
        logic busy_pending;
        logic busy_mode;
        logic pre;
        logic [3:0] bits;
        logic [RESULT_BITS-1:0] shreg;
        logic [RESULT_BITS-1:0] last_word;
        logic serial_result_out;
        logic oe_n;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    logic start_fall;
    logic start_rise;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic start_now;
    logic take_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RESULT_BITS-1:0] fifo_out_data;
    logic [RESULT_BITS-1:0] sar_result;
    logic [RESULT_BITS-1:0] frame_word;

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    assign start_fall = st.start_s3 && !st.start_s2;
    assign start_rise = !st.start_s3 && st.start_s2;
    assign cs_fall = st.cs_s3 && !st.cs_s2;
    assign cs_rise = !st.cs_s3 && st.cs_s2;
    assign sclk_fall = st.sclk_s3 && !st.sclk_s2;
    assign frame_word = fifo_out_valid ? fifo_out_data : st.last_word;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    sar_stepper u_stepper (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_start(start_now),
        .i_comparator_high(i_comparator_high),
        .o_dac_code(o_dac_code),
        .o_done(),
        .o_result(sar_result)
    );

    // A full buffer refuses new conversions; a start taken while a result is still being pushed into the last free slot can lose its own result
    sample_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_in_valid(st.push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(st.push_word),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(take_word),
        .o_out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        start_now = 1'b0;
        take_word = 1'b0;
        next_st.push = 1'b0;

        next_st.start_s1 = i_conversion_start_n;
        next_st.start_s2 = st.start_s1;
        next_st.start_s3 = st.start_s2;
        next_st.cs_s1 = i_frame_select_n;
        next_st.cs_s2 = st.cs_s1;
        next_st.cs_s3 = st.cs_s2;
        next_st.sclk_s1 = i_serial_clock;
        next_st.sclk_s2 = st.sclk_s1;
        next_st.sclk_s3 = st.sclk_s2;

        case (st.mode)
            ST_IDLE:
            begin
                // Start falls in other states fall through unanswered
                if (start_fall && fifo_in_ready)
                begin
                    start_now = 1'b1;
                    next_st.track = 1'b0;
                    next_st.count = COUNT_W'(CONV_CYCLES - 1);
                    next_st.mode = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (st.count == '0)
                begin
                    next_st.track = 1'b1;
                    next_st.push = 1'b1;
                    next_st.push_word = sar_result;
                    next_st.busy_pending = !st.cs_s2;
                    if (!st.start_s2)
                    begin
                        next_st.analog_on = 1'b0;
                        next_st.mode = ST_DOWN;
                    end
                    else
                    begin
                        next_st.mode = ST_IDLE;
                    end
                end
                else
                begin
                    next_st.count = st.count - 1'b1;
                end
            end
            ST_DOWN:
            begin
                // Falls are ignored here; only a rise wakes the part
                if (start_rise)
                begin
                    next_st.analog_on = 1'b1;
                    next_st.count = COUNT_W'(POWERUP_CYCLES - 1);
                    next_st.mode = ST_POWER_UP;
                end
            end
            ST_POWER_UP:
            begin
                if (st.count == '0)
                begin
                    next_st.mode = ST_IDLE;
                end
                else
                begin
                    next_st.count = st.count - 1'b1;
                end
            end
            default:
            begin
                next_st.mode = ST_IDLE;
            end
        endcase

        // Readout ignores the mode, so a powered-down part still answers
        if (st.busy_pending && fifo_out_valid)
        begin
            // Busy indicator: line driven low until the first clock fall
            take_word = 1'b1;
            next_st.busy_pending = 1'b0;
            next_st.busy_mode = 1'b1;
            next_st.last_word = fifo_out_data;
            next_st.shreg = fifo_out_data;
            next_st.serial_result_out = 1'b0;
            next_st.oe_n = 1'b0;
            next_st.pre = 1'b1;
            next_st.bits = 4'h0;
        end
        else if (cs_fall && !st.busy_mode)
        begin
            // Empty buffer repeats the last word read
            take_word = fifo_out_valid;
            next_st.last_word = frame_word;
            next_st.serial_result_out = frame_word[RESULT_BITS-1];
            next_st.shreg = {frame_word[RESULT_BITS-2:0], 1'b0};
            next_st.oe_n = 1'b0;
            next_st.pre = 1'b0;
            next_st.bits = 4'h1;
        end
        else if (sclk_fall && !st.oe_n)
        begin
            if (st.pre)
            begin
                next_st.serial_result_out = st.shreg[RESULT_BITS-1];
                next_st.shreg = {st.shreg[RESULT_BITS-2:0], 1'b0};
                next_st.pre = 1'b0;
                next_st.bits = 4'h1;
            end
            else if (st.bits == WORD_BITS)
            begin
                if (st.busy_mode)
                begin
                    // Thirteenth fall releases the line
                    next_st.oe_n = 1'b1;
                    next_st.busy_mode = 1'b0;
                end
                else
                begin
                    next_st.serial_result_out = 1'b0;
                end
            end
            else
            begin
                next_st.serial_result_out = st.shreg[RESULT_BITS-1];
                next_st.shreg = {st.shreg[RESULT_BITS-2:0], 1'b0};
                next_st.bits = st.bits + 4'h1;
            end
        end

        if (cs_rise)
        begin
            next_st.oe_n = 1'b1;
            next_st.busy_mode = 1'b0;
            next_st.busy_pending = 1'b0;
            next_st.pre = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st <= '0;
            st.start_s1 <= 1'b1;
            st.start_s2 <= 1'b1;
            st.start_s3 <= 1'b1;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.cs_s3 <= 1'b1;
            st.mode <= ST_IDLE;
            st.track <= 1'b1;
            st.analog_on <= 1'b1;
            st.push_word <= RESULT_RESET;
            st.last_word <= RESULT_RESET;
            st.oe_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_serial_result_out = st.serial_result_out;
    assign o_serial_result_oe_n = st.oe_n;
    assign o_track_mode = st.track;
    assign o_analog_power_on = st.analog_on;

endmodule
`default_nettype wire

// ---- tb/sar_adc_conversion_control_properties.sv ----
/*
 * Timing checker for the converter control block, bound to its top.
 * Assumes host pins change on falling edges of the reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control_properties (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_conversion_start_n,
    input wire logic i_frame_select_n,
    input wire logic i_serial_clock,
    input wire logic i_comparator_high,
    input wire logic o_serial_result_out,
    input wire logic o_serial_result_oe_n,
    input wire logic o_track_mode,
    input wire logic o_analog_power_on,
    input wire logic [sar_ctrl_pkg::RESULT_BITS-1:0] o_dac_code
);
    import sar_ctrl_pkg::*;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    // --------
    // Helpers
    // --------
    // Ten cycles of margin absorb synchroniser jitter
    localparam int QUIET_CYCLES = POWERUP_CYCLES - 10;
    logic [3:0] start_hist;
    logic [12:0] pu_count;

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            start_hist <= 4'hF;
            pu_count <= 13'h0000;
        end
        else
        begin
            start_hist <= {start_hist[2:0], i_conversion_start_n};
            if ($rose(o_analog_power_on))
                pu_count <= 13'h0001;
            else if (pu_count == 13'(QUIET_CYCLES))
                pu_count <= 13'h0000;
            else if (pu_count != 13'h0000)
                pu_count <= pu_count + 13'h0001;
        end
    end

    // --------
    // Properties
    // --------
    sequence s_conv_body;
        ##25 !o_track_mode ##1 o_track_mode;
    endsequence

    sequence s_wake;
        ##[1:5] o_analog_power_on;
    endsequence

    property p_conv_length;
        $fell(o_track_mode) |-> s_conv_body;
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion length wrong");

    property p_first_trial;
        $fell(o_track_mode) |-> o_dac_code == SAR_FIRST_TRIAL;
    endproperty
    a_first_trial: assert property (p_first_trial)
        else $error("first trial code wrong");

    property p_eoc_normal;
        $rose(o_track_mode) && start_hist[3:1] == 3'h7 |-> o_analog_power_on;
    endproperty
    a_eoc_normal: assert property (p_eoc_normal)
        else $error("powered down with start high");

    property p_eoc_down;
        $rose(o_track_mode) && start_hist[3:1] == 3'h0 |-> !o_analog_power_on;
    endproperty
    a_eoc_down: assert property (p_eoc_down)
        else $error("no power-down with start low");

    property p_down_at_eoc;
        $fell(o_analog_power_on) |-> $rose(o_track_mode);
    endproperty
    a_down_at_eoc: assert property (p_down_at_eoc)
        else $error("power-down outside end of conversion");

    property p_stay_down;
        !o_analog_power_on && start_hist == 4'h0 && !i_conversion_start_n
            |=> !o_analog_power_on;
    endproperty
    a_stay_down: assert property (p_stay_down)
        else $error("woke with start low");

    property p_wake;
        !o_analog_power_on && $rose(i_conversion_start_n) |-> s_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no power-up after start rise");

    property p_powerup_quiet;
        pu_count != 13'h0000 |-> o_track_mode;
    endproperty
    a_powerup_quiet: assert property (p_powerup_quiet)
        else $error("conversion during power-up");

    property p_frame_idle;
        i_frame_select_n [*6] |-> o_serial_result_oe_n;
    endproperty
    a_frame_idle: assert property (p_frame_idle)
        else $error("data driven without frame");

    property p_sdo_on_fall;
        !o_serial_result_oe_n && !$past(o_serial_result_oe_n) && $changed(o_serial_result_out)
            |-> !$past(i_serial_clock, 2);
    endproperty
    a_sdo_on_fall: assert property (p_sdo_on_fall)
        else $error("data changed off serial clock fall");
endmodule

bind sar_adc_conversion_control sar_adc_conversion_control_properties props (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_conversion_start_n(i_conversion_start_n), .i_frame_select_n(i_frame_select_n),
    .i_serial_clock(i_serial_clock), .i_comparator_high(i_comparator_high),
    .o_serial_result_out(o_serial_result_out), .o_serial_result_oe_n(o_serial_result_oe_n),
    .o_track_mode(o_track_mode), .o_analog_power_on(o_analog_power_on),
    .o_dac_code(o_dac_code)
);

`default_nettype wire

// ---- tb/host_model.sv ----
/*
 * Host controller model: conversion start, frame select, serial clock.
 * Assumes the caller waits out conversion and power-up before acting.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic i_ref_clk,
    input wire logic i_serial_result_out,
    output logic o_conversion_start_n,
    output logic o_frame_select_n,
    output logic o_serial_clock
);
    // Serial clock stands still low outside frames
    initial
    begin
        o_conversion_start_n = 1'b1;
        o_frame_select_n = 1'b1;
        o_serial_clock = 1'b0;
    end

    task automatic set_start(input logic level);
        @(negedge i_ref_clk);
        o_conversion_start_n = level;
    endtask

    task automatic set_cs(input logic level);
        @(negedge i_ref_clk);
        o_frame_select_n = level;
    endtask

    // Released well before end of conversion to stay in normal mode
    task automatic start_conv(input int low);
        set_start(1'b0);
        repeat (low - 1) @(negedge i_ref_clk);
        set_start(1'b1);
    endtask

    // 200 ns link clock moved on reference falling edges;
    // sampled late in the high phase where the bit has settled
    task automatic read_word(input bit busy, output logic [11:0] word, output logic lead);
        logic [12:0] s;
        s = 13'h0000;
        for (int k = 0; k < 13; k++)
        begin
            @(negedge i_ref_clk);
            o_serial_clock = 1'b1;
            repeat (4) @(negedge i_ref_clk);
            s = {s[11:0], i_serial_result_out};
            o_serial_clock = 1'b0;
            repeat (3) @(negedge i_ref_clk);
        end
        word = busy ? s[11:0] : s[12:1];
        lead = busy ? s[12] : s[0];
    endtask
endmodule

`default_nettype wire

// ---- tb/sar_adc_conversion_control_tb.sv ----
/*
 * Self-checking bench: table of conversions, then refused starts,
 * buffer fill and drain, busy readout and power-down.
 * Assumes a pull-up on the data pin and an ideal comparator.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control_tb;
    import sar_ctrl_pkg::*;

    typedef struct {
        logic [11:0] vin;
        int low;
        logic [11:0] code;
    } row_t;

    localparam int LIMIT = 20000;
    row_t rows [6] = '{
        '{12'h000, 4, 12'h000}, '{12'hFFF, 20, 12'hFFF}, '{12'h800, 4, 12'h800},
        '{12'h7FF, 20, 12'h7FF}, '{12'h001, 4, 12'h001}, '{12'hA5C, 4, 12'hA5C}
    };

    logic i_ref_clk;
    logic i_reset;
    logic cmp;
    logic [11:0] vin;
    logic [11:0] dac;
    logic start_n, cs_n, sclk, serial_result_out, oe_n, track, pwr, sdo_pin;
    logic [11:0] fill [FIFO_DEPTH];
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    // Pull-up takes the pin whenever the block lets go
    assign sdo_pin = oe_n ? 1'b1 : serial_result_out;

    sar_adc_conversion_control dut (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_conversion_start_n(start_n),
        .i_frame_select_n(cs_n), .i_serial_clock(sclk), .i_comparator_high(cmp),
        .o_serial_result_out(serial_result_out), .o_serial_result_oe_n(oe_n), .o_track_mode(track),
        .o_analog_power_on(pwr), .o_dac_code(dac)
    );

    host_model host (
        .i_ref_clk(i_ref_clk), .i_serial_result_out(sdo_pin),
        .o_conversion_start_n(start_n), .o_frame_select_n(cs_n), .o_serial_clock(sclk)
    );

    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    always @(negedge i_ref_clk)
        cmp <= (vin >= dac);

    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            $display("timeout after %0d cycles", cyc);
            test_done();
        end
    end

    // --------
    // Tasks
    // --------
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_track(input logic level);
        for (int k = 0; k < 200 && track !== level; k++)
            @(negedge i_ref_clk);
    endtask

    // Low time of zero holds the start pin low through end of conversion
    task automatic conv(input logic [11:0] v, input int low);
        vin = v;
        if (low > 0)
            host.start_conv(low);
        else
            host.set_start(1'b0);
        wait_track(1'b0);
        wait_track(1'b1);
        check("eoc", 12'(track), 12'h001);
        repeat (4) @(negedge i_ref_clk);
    endtask

    // Frame already selected at end of conversion means busy readout
    task automatic rd(input logic [11:0] exp);
        logic [11:0] w;
        logic lead;
        bit busy;
        busy = !cs_n;
        if (!busy)
            host.set_cs(1'b0);
        repeat (4) @(negedge i_ref_clk);
        host.read_word(busy, w, lead);
        check("word", w, exp);
        repeat (4) @(negedge i_ref_clk);
        if (busy)
            check("busy_lead", 12'(lead), 12'h000);
        if (busy)
            check("busy_release", 12'(oe_n), 12'h001);
        host.set_cs(1'b1);
        repeat (6) @(negedge i_ref_clk);
        check("sdo_idle", 12'(sdo_pin), 12'h001);
    endtask

    // --------
    // Sequence
    // --------
    initial
    begin
        i_reset = 1'b1;
        cmp = 1'b0;
        vin = 12'h000;
        repeat (2) @(negedge i_ref_clk);
        check("reset_pins", 12'({serial_result_out, oe_n, track, pwr}), 12'h007);
        check("reset_dac", dac, RESULT_RESET);
        repeat (3) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_reset = 1'b0;
        foreach (rows[i])
        begin
            conv(rows[i].vin, rows[i].low);
            rd(rows[i].code);
        end
        // Second fall lands mid-conversion
        vin = 12'h333;
        host.start_conv(4);
        host.start_conv(4);
        wait_track(1'b1);
        repeat (8) @(negedge i_ref_clk);
        check("refire", 12'(track), 12'h001);
        rd(12'h333);
        for (int k = 0; k < FIFO_DEPTH; k++)
        begin
            fill[k] = 12'h0F1 * 12'(k + 1);
            conv(fill[k], 4);
        end
        host.start_conv(4);
        repeat (8) @(negedge i_ref_clk);
        check("full_refuse", 12'(track), 12'h001);
        for (int k = 0; k < FIFO_DEPTH; k++)
            rd(fill[k]);
        rd(fill[FIFO_DEPTH-1]);
        host.set_cs(1'b0);
        conv(12'h3C5, 4);
        rd(12'h3C5);
        conv(12'h5A5, 0);
        check("power_down", 12'(pwr), 12'h000);
        rd(12'h5A5);
        check("still_down", 12'(pwr), 12'h000);
        host.set_start(1'b1);
        repeat (6) @(negedge i_ref_clk);
        check("wake", 12'(pwr), 12'h001);
        host.start_conv(4);
        repeat (8) @(negedge i_ref_clk);
        check("wake_refuse", 12'(track), 12'h001);
        repeat (POWERUP_CYCLES) @(negedge i_ref_clk);
        conv(12'hC3A, 4);
        rd(12'hC3A);
        test_done();
    end
endmodule

`default_nettype wire
